// file: gen3_link_capability_regs.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "gen3_cap_params.svh"

module gen3_link_capability_regs #(
  parameter logic [7:0] NEXT_CAP_PTR = 8'h00,
  parameter bit FULL_BLOCK = 1'b1,
  parameter bit SINGLE_LINK = 1'b0,
  parameter bit TUNNEL = 1'b1,
  parameter bit SELF_TEST_CAPABLE = 1'b1,
  parameter bit UNTHROTTLED_CMD_CAPABLE = 1'b0,
  parameter bit CMD_INSERTION_CAPABLE = 1'b0,
  parameter bit DEEP_STATE_CAPABLE = 1'b0,
  parameter bit SPLIT_LANE_CONTROL_CAPABLE = 1'b0,
  parameter bit ASYNC_CLOCKING = 1'b0,
  parameter int CLK_PERIOD_NS = 40,
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic train0_start_i,
  input wire logic full_training_i,
  output logic train0_done_o,
  output logic train0_active_o,
  output logic [31:0] shared_link_training_o,
  output logic [1:0] bank_select_o
);

  localparam int WORDS_PER_BANK = 9;
  localparam int STORE_WORDS = 3 * WORDS_PER_BANK;
  localparam int DWELL_W = 16;
  // length of one 100 ns unit in ns; dwell_cycles rounds up to cycles so the dwell never comes up short
  localparam int UNIT_CYC_NUM = `DWELL_UNIT_NS;

  // parameter sets that the logic cannot serve stop elaboration
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must cover the 40-byte capability");
  end
  if (CLK_PERIOD_NS < 1 || CLK_PERIOD_NS > 1000) begin : g_bad_period
    $error("CLK_PERIOD_NS outside the range the dwell counter serves");
  end
  if (!FULL_BLOCK && (!SINGLE_LINK || ASYNC_CLOCKING || TUNNEL)) begin : g_bad_reduced
    $error("reduced block is only for synchronous single-link devices");
  end
  if (SELF_TEST_CAPABLE && !FULL_BLOCK) begin : g_bad_self_test
    $error("self-test banks need the full block");
  end
  if (SINGLE_LINK && TUNNEL) begin : g_bad_flavour
    $error("a tunnel carries two links");
  end
  if (NEXT_CAP_PTR[1:0] != 2'b00) begin : g_bad_next_ptr
    $error("next capability pointer must be dword aligned");
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------

  // offset inside the block the current bank can answer
  function automatic logic offset_mapped(input logic [7:0] ofs, input logic [1:0] bank);
    logic ok;
    ok = 1'b0;
    if (ofs == `OFS_HEADER) begin
      ok = 1'b1;
    end else if (bank == 2'h3) begin
      ok = 1'b0;
    end else if (bank != `BANK_REGULAR && !SELF_TEST_CAPABLE) begin
      ok = 1'b0;
    end else if (FULL_BLOCK) begin
      ok = (ofs <= `OFS_LAST_FULL);
    end else begin
      ok = (ofs <= `OFS_LAST_REDUCED);
    end
    return ok;
  endfunction

  // dwords that read as zero and drop writes
  function automatic logic offset_reserved(input logic [7:0] ofs, input logic [1:0] bank);
    logic rsvd;
    rsvd = 1'b0;
    if (bank == `BANK_REGULAR) begin
      if (ofs == `OFS_REGULAR_RSVD) begin
        rsvd = 1'b1;
      end else if (SINGLE_LINK && (ofs == `OFS_LINK1_TX_CFG || ofs == `OFS_LINK1_RX_CFG
                                   || ofs == `OFS_LINK1_TRAIN)) begin
        rsvd = 1'b1;
      end
    end else if (bank == `BANK_TX_TEST && ofs == `OFS_TX_TEST_RSVD) begin
      rsvd = 1'b1;
    end
    return rsvd;
  endfunction

  // flat storage index: each bank owns its own nine words
  function automatic logic [4:0] store_index(input logic [7:0] ofs, input logic [1:0] bank);
    logic [4:0] word;
    word = 5'(ofs[7:2]) - 5'h01;
    return 5'(bank) * 5'(WORDS_PER_BANK) + word;
  endfunction

  // the shared training word lives only in the regular bank
  function automatic logic is_shared_train(input logic [7:0] ofs, input logic [1:0] bank);
    return bank == `BANK_REGULAR && ofs == `OFS_GLOBAL_TRAIN;
  endfunction

  // dwell code to 100 ns units: count times scale, scale 3 clamped at 200 us
  function automatic logic [DWELL_W-1:0] dwell_units(input logic [5:0] code);
    logic [3:0] count;
    logic [8:0] mult;
    count = code[3:0];
    mult = `DWELL_MULT_S0;
    case (code[5:4])
      2'h0: mult = `DWELL_MULT_S0;
      2'h1: mult = `DWELL_MULT_S1;
      2'h2: mult = `DWELL_MULT_S2;
      default: begin
        mult = `DWELL_MULT_S3;
        if (count > `DWELL_S3_MAX_COUNT) begin
          count = `DWELL_S3_MAX_COUNT;
        end
      end
    endcase
    return DWELL_W'(count) * DWELL_W'(mult);
  endfunction

  // units to cycles, rounded up so the programmed time is never undercut
  function automatic logic [DWELL_W+4:0] dwell_cycles(input logic [DWELL_W-1:0] units);
    logic [DWELL_W+10:0] ns;
    ns = (DWELL_W+11)'(units) * (DWELL_W+11)'(UNIT_CYC_NUM);
    return (DWELL_W+5)'((ns + (DWELL_W+11)'(CLK_PERIOD_NS - 1))
                        / (DWELL_W+11)'(CLK_PERIOD_NS));
  endfunction

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------

  gen3_cap_pkg::bank_sel_t bank;
  logic [31:0] glt;
  logic [31:0] store [0:STORE_WORDS-1];
  gen3_cap_pkg::apb_state_t apb_state;
  logic [7:0] ofs;
  logic hit;
  logic upper_zero;
  logic write_go;
  logic [31:0] glt_mask;
  logic [31:0] header_word;
  logic [31:0] next_rdata;
  logic next_err;
  logic [5:0] feature_enumeration;

  assign ofs = 8'({paddr_i[ADDR_W-1:2], 2'b00});
  // wider buses must not alias the capability onto higher addresses
  if (ADDR_W > 8) begin : g_upper
    assign upper_zero = (paddr_i[ADDR_W-1:8] == '0);
  end else begin : g_no_upper
    assign upper_zero = 1'b1;
  end
  assign hit = upper_zero && offset_mapped(ofs, bank);

  // bit 23 stays zero
  assign feature_enumeration = {
    1'b0,
    SPLIT_LANE_CONTROL_CAPABLE,
    DEEP_STATE_CAPABLE,
    CMD_INSERTION_CAPABLE,
    (FULL_BLOCK && SELF_TEST_CAPABLE),
    UNTHROTTLED_CMD_CAPABLE
  };

  assign header_word = {
    `CAP_TYPE_VALUE,
    feature_enumeration,
    (SELF_TEST_CAPABLE ? bank : 2'h0),
    NEXT_CAP_PTR,
    `CAP_ID_VALUE
  };

  // writable bits of the shared training register depend on the device flavour
  always_comb begin
    glt_mask = `GLT_BASE_MASK;
    if (!SPLIT_LANE_CONTROL_CAPABLE) begin
      glt_mask = glt_mask | `GLT_INLN_MASK;
    end
    if (TUNNEL) begin
      glt_mask = glt_mask | `GLT_TUNNEL_LINK_SELECT_MASK;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (!hit) begin
      next_err = 1'b1;
    end else if (ofs == `OFS_HEADER) begin
      next_rdata = header_word;
    end else if (offset_reserved(ofs, bank)) begin
      next_rdata = 32'h0000_0000;
    end else if (is_shared_train(ofs, bank)) begin
      next_rdata = glt;
    end else begin
      next_rdata = store[store_index(ofs, bank)];
    end
  end

  // ---------------------------------------------------------------------------
  // apb slave: one wait state so read data comes from a flop
  // ce low freezes the slave; a write whose ready edge sees ce low is dropped and pready stays high
  // ---------------------------------------------------------------------------

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      apb_state <= gen3_cap_pkg::apb_idle;
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      case (apb_state)
        gen3_cap_pkg::apb_idle: begin
          if (psel_i && penable_i) begin
            apb_state <= gen3_cap_pkg::apb_answer;
            pready_o <= 1'b1;
            pslverr_o <= next_err;
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
          end
        end
        default: begin
          apb_state <= gen3_cap_pkg::apb_idle;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
          prdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // a write lands on the edge where the master sees pready high
  assign write_go = ce_i && psel_i && penable_i && pwrite_i && pready_o && hit
                    && !offset_reserved(ofs, bank);

  // 11b is kept as written; only the header answers in that bank
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank <= `BANK_REGULAR;
    end else if (write_go && ofs == `OFS_HEADER && SELF_TEST_CAPABLE) begin
      bank <= pwdata_i[`HDR_BANK_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      glt <= `GLT_RESET;
    end else if (write_go && is_shared_train(ofs, bank)) begin
      // the dwell code is not locked here; keeping it steady is up to software
      glt <= pwdata_i & glt_mask;
    end
  end

  // each bank has its own words, so test setups never clobber link registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < STORE_WORDS; i++) begin
        store[i] <= 32'h0000_0000;
      end
    end else if (write_go && ofs != `OFS_HEADER && !is_shared_train(ofs, bank)) begin
      store[store_index(ofs, bank)] <= pwdata_i;
    end
  end

  // one copy feeds both links of a tunnel
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shared_link_training_o <= `GLT_RESET;
    end else if (ce_i) begin
      shared_link_training_o <= glt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank_select_o <= `BANK_REGULAR;
    end else if (ce_i) begin
      bank_select_o <= bank;
    end
  end

  // ---------------------------------------------------------------------------
  // training-0 dwell timer
  // ---------------------------------------------------------------------------

  gen3_cap_pkg::dwell_state_t dwell_state;
  logic [DWELL_W+4:0] dwell_count;
  logic [5:0] dwell_code;
  logic [DWELL_W+4:0] dwell_target;

  // full training with an unprogrammed field falls back to 200 us
  always_comb begin
    dwell_code = glt[`GLT_T0_LSB +: 6];
    if (full_training_i) begin
      dwell_code = glt[`GLT_FULLT0_LSB +: 6];
      if (dwell_code == 6'h00) begin
        dwell_code = `DWELL_FULL_DEFAULT;
      end
    end
  end

  assign dwell_target = dwell_cycles(dwell_units(dwell_code));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dwell_state <= gen3_cap_pkg::dwell_idle;
      dwell_count <= '0;
      train0_done_o <= 1'b0;
      train0_active_o <= 1'b0;
    end else if (ce_i) begin
      train0_done_o <= 1'b0;
      case (dwell_state)
        // a start during the done cycle is dropped; callers wait for done
        gen3_cap_pkg::dwell_idle: begin
          if (train0_start_i) begin
            dwell_count <= dwell_target;
            train0_active_o <= 1'b1;
            dwell_state <= gen3_cap_pkg::dwell_run;
          end
        end
        gen3_cap_pkg::dwell_run: begin
          // a zero code ends after one cycle, which is within the 100 ns slack
          if (dwell_count <= (DWELL_W+5)'(1)) begin
            dwell_state <= gen3_cap_pkg::dwell_done;
          end else begin
            dwell_count <= dwell_count - (DWELL_W+5)'(1);
          end
        end
        default: begin
          train0_done_o <= 1'b1;
          train0_active_o <= 1'b0;
          dwell_count <= '0;
          dwell_state <= gen3_cap_pkg::dwell_idle;
        end
      endcase
    end
  end

endmodule // gen3_link_capability_regs

// file: gen3_cap_params.svh
`ifndef GEN3_CAP_PARAMS_SVH
`define GEN3_CAP_PARAMS_SVH

// dword byte offsets inside the capability
`define OFS_HEADER 8'h00
`define OFS_GLOBAL_TRAIN 8'h04
`define OFS_LINK0_TX_CFG 8'h08
`define OFS_LINK0_RX_CFG 8'h0c
`define OFS_LINK0_TRAIN 8'h10
`define OFS_REGULAR_RSVD 8'h14
`define OFS_LINK1_TX_CFG 8'h18
`define OFS_LINK1_RX_CFG 8'h1c
`define OFS_LINK1_TRAIN 8'h20
`define OFS_SELF_TEST_CTRL 8'h24
`define OFS_TX_TEST_RSVD 8'h24
`define OFS_LAST_REDUCED 8'h14
`define OFS_LAST_FULL 8'h24

// header layout
`define CAP_ID_VALUE 8'h08
`define CAP_TYPE_VALUE 8'hd0
`define HDR_ID_LSB 0
`define HDR_PTR_LSB 8
`define HDR_BANK_LSB 16
`define HDR_ENUM_LSB 18
`define ENUM_UNTHROTTLED 0
`define ENUM_SELF_TEST 1
`define ENUM_CMD_INSERT 2
`define ENUM_DEEP_STATE 3
`define ENUM_SPLIT_LANE 4
`define HDR_TYPE_LSB 24

// bank codes
`define BANK_REGULAR 2'h0
`define BANK_RX_TEST 2'h1
`define BANK_TX_TEST 2'h2

// shared link training register
`define GLT_RESET 32'h0074003a
`define GLT_T0_LSB 0
`define GLT_INLN_LSB 6
`define GLT_TUNNEL_LINK_SELECT_BIT 12
`define GLT_FULLT0_LSB 17
`define GLT_BASE_MASK 32'h007c0f3f
`define GLT_INLN_MASK 32'h000000c0
`define GLT_TUNNEL_LINK_SELECT_MASK 32'h00001000

// dwell timing: unit is 100 ns, scale multipliers and the ceiling code
`define DWELL_UNIT_NS 100
`define DWELL_MULT_S0 9'h001
`define DWELL_MULT_S1 9'h005
`define DWELL_MULT_S2 9'h014
`define DWELL_MULT_S3 9'h0c8
`define DWELL_S3_MAX_COUNT 4'ha
`define DWELL_FULL_DEFAULT 6'h3a

`endif

// file: gen3_cap_pkg.sv
package gen3_cap_pkg;

  typedef logic [1:0] bank_sel_t;

  typedef enum logic [1:0] {
    dwell_idle,
    dwell_run,
    dwell_done
  } dwell_state_t;

  typedef enum logic [1:0] {
    apb_idle,
    apb_answer
  } apb_state_t;

endpackage

// file: gen3_link_capability_regs_props.sv
`timescale 1ns/1ps
module gen3_link_capability_regs_props #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic train0_start_i,
  input wire logic full_training_i,
  input wire logic train0_done_o,
  input wire logic train0_active_o,
  input wire logic [31:0] shared_link_training_o,
  input wire logic [1:0] bank_select_o
);
  logic hdr_rd;
  logic dwell_go;
  assign hdr_rd = pready_o && !pwrite_i && paddr_i[ADDR_W-1:2] == '0 && !pslverr_o;
  // the register copy lags one cycle, so a start on the first edge after a code write lands is judged by the previous code
  assign dwell_go = train0_start_i && ce_i && !train0_active_o && !train0_done_o
    && !full_training_i && shared_link_training_o[5:0] == 6'h01;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_hdr_id_ptr: assert property (hdr_rd |-> prdata_o[15:0] == 16'h0008)
    else $error("header id or pointer wrong");
  chk_hdr_type: assert property (hdr_rd |-> prdata_o[31:24] == 8'hd0)
    else $error("header type wrong");
  chk_enum_bits: assert property (hdr_rd |->
      prdata_o[23:18] == 6'h02)
    else $error("feature bits wrong");
  chk_bank_echo: assert property (hdr_rd |-> prdata_o[17:16] == bank_select_o)
    else $error("bank field differs from bank output");
  chk_one_wait: assert property (psel_i && penable_i && ce_i && !pready_o |=> pready_o)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_err_zero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
    else $error("error answer with data");
  chk_dwell_exact: assert property (dwell_go |=>
      train0_active_o [*4] ##1 (train0_done_o && !train0_active_o))
    else $error("shortest dwell timing wrong");
  chk_done_pulse: assert property (train0_done_o |=> !train0_done_o && !train0_active_o)
    else $error("done not a single pulse");
  cov_hdr: cover property (hdr_rd);
  cov_err: cover property (pready_o && pslverr_o);
  cov_done: cover property (train0_done_o);
endmodule // gen3_link_capability_regs_props

bind gen3_link_capability_regs gen3_link_capability_regs_props #(.ADDR_W(ADDR_W)) u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .train0_start_i(train0_start_i), .full_training_i(full_training_i),
  .train0_done_o(train0_done_o), .train0_active_o(train0_active_o),
  .shared_link_training_o(shared_link_training_o), .bank_select_o(bank_select_o)
);

// file: gen3_link_capability_regs_tb.sv
`timescale 1ns/1ps
module gen3_link_capability_regs_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic train0_start_i = 1'b0;
  logic full_training_i = 1'b0;
  logic [31:0] prdata_o;
  logic [31:0] shared_link_training_o;
  logic [1:0] bank_select_o;
  logic pready_o, pslverr_o, train0_done_o, train0_active_o;
  int error_cnt = 0;
  int checked = 0;
  logic [5:0] codes[5] = '{6'h00, 6'h01, 6'h11, 6'h3f, 6'h00};
  logic fulls[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  // active lasts the counted cycles, at least one, plus the cycle that raises done
  int n_exp[5] = '{2, 4, 14, 5001, 5001};

  always #20 clk_i = ~clk_i;

  gen3_link_capability_regs uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .train0_start_i(train0_start_i), .full_training_i(full_training_i),
    .train0_done_o(train0_done_o), .train0_active_o(train0_active_o),
    .shared_link_training_o(shared_link_training_o), .bank_select_o(bank_select_o)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one transfer; read data is compared only on reads, the error flag always
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err, input string name);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      report_and_stop;
    end
    if (!wr) check(name, prdata_o, exp);
    check({name, "_err"}, {31'h0, pslverr_o}, {31'h0, err});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // counts the cycles the dwell stays active before its done pulse
  task automatic dwell(input logic [5:0] code, input logic full, input int n_want);
    int n;
    bit seen;
    acc(1'b1, 8'h04, {26'h0, code}, 32'h0, 1'b0, "dwell_code");
    full_training_i <= full;
    train0_start_i <= 1'b1;
    @(posedge clk_i);
    train0_start_i <= 1'b0;
    n = 0;
    seen = 0;
    for (int k = 0; k < 6000 && !seen; k++) begin
      @(negedge clk_i);
      if (train0_done_o === 1'b1) seen = 1;
      else if (train0_active_o === 1'b1) n++;
    end
    if (!seen) begin
      error_cnt++;
      report_and_stop;
    end
    check("dwell_cycles", n, n_want);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    check("train_out", shared_link_training_o, 32'h0074003a);
    acc(1'b0, 8'h00, 32'h0, 32'hd0080008, 1'b0, "hdr");
    acc(1'b0, 8'h04, 32'h0, 32'h0074003a, 1'b0, "train");
    acc(1'b1, 8'h04, 32'hffffffff, 32'h0, 1'b0, "train_w");
    acc(1'b0, 8'h04, 32'h0, 32'h007c1fff, 1'b0, "train_rw");
    check("train_out", shared_link_training_o, 32'h007c1fff);
    $display("test reset and training register done");
    for (int i = 0; i < 5; i++) dwell(codes[i], fulls[i], n_exp[i]);
    $display("test dwell done");
    acc(1'b1, 8'h00, 32'h00010000, 32'h0, 1'b0, "bank_w");
    acc(1'b0, 8'h00, 32'h0, 32'hd0090008, 1'b0, "hdr_b1");
    check("bank_out", {30'h0, bank_select_o}, 32'h1);
    for (int i = 1; i < 10; i++) acc(1'b1, 8'(i * 4), 32'ha5000000 | i, 32'h0, 1'b0, "rx_w");
    acc(1'b1, 8'h00, 32'h00020000, 32'h0, 1'b0, "bank_w");
    for (int i = 1; i < 10; i++) acc(1'b1, 8'(i * 4), 32'h5a000000 | i, 32'h0, 1'b0, "tx_w");
    for (int i = 1; i < 9; i++) begin
      acc(1'b0, 8'(i * 4), 32'h0, 32'h5a000000 | i, 1'b0, "tx_r");
    end
    acc(1'b0, 8'h24, 32'h0, 32'h0, 1'b0, "tx_rsvd");
    acc(1'b1, 8'h00, 32'h00010000, 32'h0, 1'b0, "bank_w");
    for (int i = 1; i < 10; i++) begin
      acc(1'b0, 8'(i * 4), 32'h0, 32'ha5000000 | i, 1'b0, "rx_r");
    end
    acc(1'b1, 8'h00, 32'h0, 32'h0, 1'b0, "bank_w");
    acc(1'b1, 8'h08, 32'h12345678, 32'h0, 1'b0, "link0_w");
    acc(1'b0, 8'h08, 32'h0, 32'h12345678, 1'b0, "link0_r");
    acc(1'b1, 8'h14, 32'hffffffff, 32'h0, 1'b0, "rsvd_w");
    acc(1'b0, 8'h14, 32'h0, 32'h0, 1'b0, "rsvd_r");
    acc(1'b0, 8'h28, 32'h0, 32'h0, 1'b1, "unmapped");
    acc(1'b1, 8'h00, 32'hffffffff, 32'h0, 1'b0, "hdr_w");
    acc(1'b0, 8'h00, 32'h0, 32'hd00b0008, 1'b0, "hdr_ro");
    acc(1'b0, 8'h04, 32'h0, 32'h0, 1'b1, "bank3");
    $display("test banks done");
    // clock enable low: a start pulse must not be taken
    ce_i <= 1'b0;
    train0_start_i <= 1'b1;
    @(posedge clk_i);
    train0_start_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("frozen_active", {31'h0, train0_active_o}, 32'h0);
    ce_i <= 1'b1;
    @(posedge clk_i);
    // reset with bank 3 selected and no dwell running brings back the cold values
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("rst_train_out", shared_link_training_o, 32'h0074003a);
    check("rst_bank_out", {30'h0, bank_select_o}, 32'h0);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    acc(1'b0, 8'h04, 32'h0, 32'h0074003a, 1'b0, "train_rst");
    acc(1'b0, 8'h00, 32'h0, 32'hd0080008, 1'b0, "hdr_rst");
    $display("test enable and reset done");
    report_and_stop;
  end
endmodule // gen3_link_capability_regs_tb
